/* fieldbus_slave_function_decoder_defs.vh */
// Constants for the fieldbus slave function decoder
`ifndef FIELDBUS_SLAVE_FUNCTION_DECODER_DEFS_VH
`define FIELDBUS_SLAVE_FUNCTION_DECODER_DEFS_VH
// Register byte offsets
`define OFS_REQ_HDR 6'h00
`define OFS_REQ_ADR 6'h04
`define OFS_REQ_LEN 6'h08
`define OFS_REQ_DAT 6'h0C
`define OFS_CTRL 6'h10
`define OFS_GO 6'h14
`define OFS_RESULT 6'h18
`define OFS_RDATA 6'h1C
`define OFS_PARAM 6'h20
`define OFS_INDEX 6'h24
`define OFS_COIL0 6'h28
`define OFS_COIL1 6'h2C
`define OFS_COIL2 6'h30
`define OFS_CNT_BUS 6'h34
`define OFS_CNT_SLV 6'h38
// Function codes
`define FN_RD_COILS 8'h01
`define FN_RD_HREGS 8'h03
`define FN_WR_COIL 8'h05
`define FN_WR_HREG 8'h06
`define FN_DIAG 8'h08
`define FN_EVT_CNT 8'h0B
`define FN_WR_COILS 8'h0F
`define FN_WR_HREGS 8'h10
`define FN_SLAVE_ID 8'h11
`define FN_RW_HREGS 8'h17
`define FN_EXC_BIT 8'h80
// Diagnostic subfunctions
`define SUB_RESTART 16'h0001
`define SUB_DIAG_REG 16'h0002
`define SUB_CLEAR 16'h000A
`define SUB_BUS_MSG 16'h000B
`define SUB_BUS_ERR 16'h000C
`define SUB_SLV_ERR 16'h000D
`define SUB_SLV_MSG 16'h000E
// Exception codes
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define EXC_FAIL 8'h04
// Address space and sizes
`define BCAST_ADDR 8'h00
`define COIL_COUNT 17'h00060
`define COIL_RD_MAX 16'h0020
`define STORE_COIL 7'h40
`define HREG_COUNT 17'h02710
`define INDEX_WIRE 16'h0008
`define PNU_SCALE 17'h0000A
`define HREG_RD_MAX 16'h000A
`define TEXT_MAX 8'h14
`define FORCE_ON 16'hFF00
`define FORCE_OFF 16'h0000
`define SPACE_CHAR 8'h20
`define SLAVE_ID 16'h5A01
`endif

/* fieldbus_slave_function_decoder.v */
// Request interpreter for a fieldbus slave, with Avalon-MM register access
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// How it works
// - Accept the ten listed function codes
// - Diagnostics subfunctions 1,2,10-14 handled
// - Exception 1: unknown function or unconfigured read
// - Exception 2: start plus length overruns
// - Exception 3: structural request faults only
// - Exception 4: internal fault blocks action
// - Register is ten times parameter number
// - Coil 65 selects nonvolatile plus RAM
// - Holding register 9 holds array index
// - Text blocks at most 20 characters
// - Long text reads truncated, short text answers cut short
// - Values cross only as scaled integers
// - Read 03, write 06 or 10
// - Parameter reads span 1 to 10
// - Text read 03, written only 10
// - Broadcast reads never acted on
// - Coil wire address is number minus one
// - Coil bits packed LSB first
// - Unused upper coil bits are zero
// - Byte count counts partial byte
// - Register wire address is number minus one
// - Two bytes per register, high first
`include "fieldbus_slave_function_decoder_defs.vh"

module fieldbus_slave_function_decoder (
    input wire clock_i,
    input wire rst_i,
    input wire [5:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    output reg [31:0] readdata_o,
    output wire waitrequest_o,
    output wire nv_store_o,
    output wire [15:0] array_index_pointer_o
);

// ****************************************
// Storage
// ****************************************
reg ack_r; // One wait state per access
reg [31:0] req_hdr_r; // Slave addr, function, check ok
reg [31:0] req_adr_r; // Start or subfn, count or data
reg [31:0] req_len_r; // Byte count, text length, kind
reg [31:0] req_dat_r; // First write data word
reg [31:0] ctrl_r; // Own addr, configured, fault, diag
reg [95:0] coil_r; // Coil image, wire address 0 at bit 0
reg [15:0] index_r; // Array index pointer
reg [31:0] result_r; // Decode outcome
reg [31:0] rdata_r; // Response payload
reg [31:0] param_r; // Parameter mapping
reg [15:0] bus_msg_r;
reg [15:0] bus_err_r;
reg [15:0] slv_err_r;
reg [15:0] slv_msg_r;

// ****************************************
// Request fields
// ****************************************
wire [7:0] slave_addr = req_hdr_r[7:0];
wire [7:0] fn = req_hdr_r[15:8];
wire check_ok = req_hdr_r[16];
wire [15:0] start = req_adr_r[15:0];
wire [15:0] qty = req_adr_r[31:16];
wire [7:0] byte_cnt = req_len_r[7:0];
wire [7:0] text_len = req_len_r[15:8];
wire is_text = req_len_r[16];
wire is_wide = req_len_r[17];
wire [7:0] own_addr = ctrl_r[7:0];
wire configured = ctrl_r[8];
wire fault = ctrl_r[9];
wire [15:0] diag_reg = ctrl_r[31:16];
wire bus_go = write_i && !ack_r && address_i == `OFS_GO;

// Decides whether a function code is one we serve
function fn_known;
    input [7:0] f;
    begin
        case (f)
            `FN_RD_COILS, `FN_RD_HREGS, `FN_WR_COIL, `FN_WR_HREG,
            `FN_DIAG, `FN_EVT_CNT, `FN_WR_COILS, `FN_WR_HREGS,
            `FN_SLAVE_ID, `FN_RW_HREGS: fn_known = 1'b1;
            default: fn_known = 1'b0;
        endcase
    end
endfunction

// Coil and register reads (01, 03, 17), which need configuration
function fn_reads;
    input [7:0] f;
    begin
        fn_reads = f == `FN_RD_COILS || f == `FN_RD_HREGS || f == `FN_RW_HREGS;
    end
endfunction

// ****************************************
// Avalon-MM slave
// ****************************************
// Waitrequest drops in the cycle after the request appears
assign waitrequest_o = (read_i || write_i) && !ack_r;
assign nv_store_o = coil_r[`STORE_COIL];
assign array_index_pointer_o = index_r;

// ****************************************
// Decoder
// ****************************************
reg [7:0] exc;
reg respond;
reg act;
reg [7:0] rbytes;
reg [31:0] rdata;
reg [16:0] reg_num;
reg [16:0] end_adr;
reg [15:0] parameter_number;
reg [3:0] word_ofs;
reg [32:0] mask;
reg [95:0] coil_nxt;
reg [15:0] index_nxt;
reg cnt_clr;
reg [7:0] chars;
reg [7:0] tlen;
reg bcast;
reg mine;
reg [16:0] pnu_full; // Quotient before trimming to 16 bits
reg [16:0] ofs_full; // Remainder before trimming to 4 bits
reg [15:0] cbytes; // Whole bytes needed for the coil count
reg [95:0] coil_shift; // Coil image moved down to the start coil

// Combinational decode of the held request
always @* begin
    exc = `EXC_NONE;
    respond = 1'b0;
    act = 1'b0;
    rbytes = 8'h00;
    rdata = 32'h00000000;
    coil_nxt = coil_r;
    index_nxt = index_r;
    cnt_clr = 1'b0;
    bcast = slave_addr == `BCAST_ADDR;
    mine = check_ok && (bcast || slave_addr == own_addr);
    // Wire addresses are one below the documented numbers
    reg_num = {1'b0, start} + 17'h00001;
    end_adr = {1'b0, start} + {1'b0, qty};
    // Parameter number and word within its ten-register slot
    pnu_full = {1'b0, reg_num[15:0]} / `PNU_SCALE;
    ofs_full = {1'b0, reg_num[15:0]} % `PNU_SCALE;
    parameter_number = pnu_full[15:0];
    word_ofs = ofs_full[3:0];
    mask = (33'h000000001 << qty[5:0]) - 33'h000000001;
    tlen = (text_len > `TEXT_MAX) ? `TEXT_MAX : text_len;
    chars = {qty[6:0], 1'b0};
    cbytes = (qty + 16'h0007) >> 3;
    coil_shift = coil_r >> start;
    if (!fn_known(fn) || (fn_reads(fn) && !configured)) begin
        exc = `EXC_FUNC;
    end else begin
        case (fn)
            `FN_RD_COILS: begin
                if (qty == 16'h0000 || qty > `COIL_RD_MAX) begin
                    exc = `EXC_VALUE;
                end else if (end_adr > `COIL_COUNT) begin
                    exc = `EXC_ADDR;
                end else begin
                    // First coil lands in bit 0, padding stays zero
                    rdata = coil_shift[31:0] & mask[31:0];
                    rbytes = cbytes[7:0];
                end
            end
            `FN_RD_HREGS, `FN_RW_HREGS: begin
                if (qty == 16'h0000 || qty > `HREG_RD_MAX) begin
                    exc = `EXC_VALUE;
                end else if (end_adr > `HREG_COUNT) begin
                    exc = `EXC_ADDR;
                end else if (is_text && chars > tlen) begin
                    // Text shorter than asked: cut the answer short
                    rbytes = tlen + {7'h00, tlen[0]};
                    rdata = {24'h000000, `SPACE_CHAR};
                end else if (is_text) begin
                    rbytes = chars;
                    rdata = {24'h000000, `SPACE_CHAR};
                end else if (start == `INDEX_WIRE) begin
                    rbytes = {qty[6:0], 1'b0};
                    rdata = {16'h0000, index_r};
                end else begin
                    rbytes = {qty[6:0], 1'b0};
                end
            end
            `FN_WR_COIL: begin
                if (qty != `FORCE_ON && qty != `FORCE_OFF) begin
                    exc = `EXC_VALUE;
                end else if ({1'b0, start} >= `COIL_COUNT) begin
                    exc = `EXC_ADDR;
                end else begin
                    coil_nxt[start[6:0]] = qty == `FORCE_ON;
                    rdata = {start, qty};
                end
            end
            `FN_WR_COILS: begin
                if (qty == 16'h0000 || qty > `COIL_RD_MAX ||
                        byte_cnt != cbytes[7:0]) begin
                    exc = `EXC_VALUE;
                end else if (end_adr > `COIL_COUNT) begin
                    exc = `EXC_ADDR;
                end else begin
                    coil_nxt = (coil_r & ~({64'h0, mask[31:0]} << start)) |
                        ({64'h0, req_dat_r & mask[31:0]} << start);
                    rdata = {start, qty};
                end
            end
            `FN_WR_HREG: begin
                if (is_text || is_wide) begin
                    exc = `EXC_VALUE;
                end else if ({1'b0, start} >= `HREG_COUNT) begin
                    exc = `EXC_ADDR;
                end else begin
                    if (start == `INDEX_WIRE) begin
                        index_nxt = qty;
                    end
                    rdata = {start, qty};
                end
            end
            `FN_WR_HREGS: begin
                if (qty == 16'h0000 || qty > `HREG_RD_MAX ||
                        byte_cnt != {qty[6:0], 1'b0} ||
                        (is_text && chars > `TEXT_MAX)) begin
                    exc = `EXC_VALUE;
                end else if (end_adr > `HREG_COUNT) begin
                    exc = `EXC_ADDR;
                end else begin
                    if (start == `INDEX_WIRE) begin
                        // High-order byte arrives first
                        index_nxt = req_dat_r[31:16];
                    end
                    rdata = {start, qty};
                end
            end
            `FN_DIAG: begin
                case (start)
                    `SUB_RESTART: begin
                        cnt_clr = 1'b1;
                        rdata = {16'h0000, qty};
                    end
                    `SUB_DIAG_REG: rdata = {16'h0000, diag_reg};
                    `SUB_CLEAR: begin
                        cnt_clr = 1'b1;
                        rdata = {16'h0000, qty};
                    end
                    `SUB_BUS_MSG: rdata = {16'h0000, bus_msg_r};
                    `SUB_BUS_ERR: rdata = {16'h0000, bus_err_r};
                    `SUB_SLV_ERR: rdata = {16'h0000, slv_err_r};
                    `SUB_SLV_MSG: rdata = {16'h0000, slv_msg_r};
                    default: exc = `EXC_FUNC;
                endcase
                rbytes = 8'h04;
            end
            `FN_EVT_CNT: begin
                rdata = {16'h0000, slv_msg_r};
                rbytes = 8'h04;
            end
            `FN_SLAVE_ID: begin
                rdata = {16'h0000, `SLAVE_ID}; // Arbitrary identity value
                rbytes = 8'h02;
            end
            default: exc = `EXC_FUNC;
        endcase
    end
    // A valid request that cannot be carried out
    if (exc == `EXC_NONE && fault) begin
        exc = `EXC_FAIL;
    end
    if (exc != `EXC_NONE) begin
        rbytes = 8'h01;
        rdata = {24'h000000, exc};
        coil_nxt = coil_r;
        index_nxt = index_r;
        cnt_clr = 1'b0;
    end
    // Broadcast reads do nothing and are never answered
    if (bcast && (fn_reads(fn) || fn == `FN_DIAG || fn == `FN_EVT_CNT ||
            fn == `FN_SLAVE_ID)) begin
        act = 1'b0;
        coil_nxt = coil_r;
        index_nxt = index_r;
        cnt_clr = 1'b0;
    end else begin
        act = mine && exc == `EXC_NONE;
    end
    respond = mine && !bcast;
    if (!mine) begin
        coil_nxt = coil_r;
        index_nxt = index_r;
        cnt_clr = 1'b0;
    end
end

// ****************************************
// Registers
// ****************************************
// Bus writes, decode commit and counters share one process
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        ack_r <= 1'b0;
        readdata_o <= 32'h00000000;
        req_hdr_r <= 32'h00000000;
        req_adr_r <= 32'h00000000;
        req_len_r <= 32'h00000000;
        req_dat_r <= 32'h00000000;
        ctrl_r <= 32'h00000000;
        coil_r <= 96'h0;
        index_r <= 16'h0000;
        result_r <= 32'h00000000;
        rdata_r <= 32'h00000000;
        param_r <= 32'h00000000;
        bus_msg_r <= 16'h0000;
        bus_err_r <= 16'h0000;
        slv_err_r <= 16'h0000;
        slv_msg_r <= 16'h0000;
    end else begin
        ack_r <= (read_i || write_i) && !ack_r;
        // Read data is captured with the acknowledge
        if (read_i && !ack_r) begin
            case (address_i)
                `OFS_REQ_HDR: readdata_o <= req_hdr_r;
                `OFS_REQ_ADR: readdata_o <= req_adr_r;
                `OFS_REQ_LEN: readdata_o <= req_len_r;
                `OFS_REQ_DAT: readdata_o <= req_dat_r;
                `OFS_CTRL: readdata_o <= ctrl_r;
                `OFS_RESULT: readdata_o <= result_r;
                `OFS_RDATA: readdata_o <= rdata_r;
                `OFS_PARAM: readdata_o <= param_r;
                `OFS_INDEX: readdata_o <= {16'h0000, index_r};
                `OFS_COIL0: readdata_o <= coil_r[31:0];
                `OFS_COIL1: readdata_o <= coil_r[63:32];
                `OFS_COIL2: readdata_o <= coil_r[95:64];
                `OFS_CNT_BUS: readdata_o <= {bus_err_r, bus_msg_r};
                `OFS_CNT_SLV: readdata_o <= {slv_msg_r, slv_err_r};
                default: readdata_o <= 32'h00000000; // Unmapped reads zero
            endcase
        end
        if (write_i && !ack_r) begin
            case (address_i)
                `OFS_REQ_HDR: req_hdr_r <= {15'h0000, writedata_i[16:0]};
                `OFS_REQ_ADR: req_adr_r <= writedata_i;
                `OFS_REQ_LEN: req_len_r <= {14'h0000, writedata_i[17:0]};
                `OFS_REQ_DAT: req_dat_r <= writedata_i;
                `OFS_CTRL: ctrl_r <= {writedata_i[31:16], 6'h00, writedata_i[9:0]};
                `OFS_COIL0: coil_r[31:0] <= writedata_i;
                `OFS_COIL1: coil_r[63:32] <= writedata_i;
                `OFS_COIL2: coil_r[95:64] <= writedata_i;
                default: ;
            endcase
        end
        // Commit a decode; coil and index updates win over bus writes
        if (bus_go) begin
            coil_r <= coil_nxt;
            index_r <= index_nxt;
            rdata_r <= rdata;
            param_r <= {12'h000, word_ofs, parameter_number};
            // Exception answer echoes function with its top bit set
            result_r <= {5'h00, coil_r[`STORE_COIL], act, respond, rbytes, exc,
                (exc != `EXC_NONE) ? (fn | `FN_EXC_BIT) : fn};
            // A clear in the same step wins, leaving only this message counted
            if (cnt_clr) begin
                bus_msg_r <= 16'h0001;
                bus_err_r <= 16'h0000;
                slv_err_r <= 16'h0000;
                slv_msg_r <= 16'h0001;
            end else begin
                bus_msg_r <= bus_msg_r + {15'h0000, check_ok};
                bus_err_r <= bus_err_r + {15'h0000, !check_ok};
                slv_err_r <= slv_err_r + {15'h0000, mine && exc != `EXC_NONE};
                slv_msg_r <= slv_msg_r + {15'h0000, mine};
            end
        end
    end
end

endmodule // fieldbus_slave_function_decoder

/* decoder_checker.sv */
// Checker for the decoder's bus timing and status outputs
`timescale 1ns/1ns
`include "fieldbus_slave_function_decoder_defs.vh"
module decoder_checker (
    input wire clock_i,
    input wire rst_i,
    input wire [5:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    input wire [31:0] readdata_o,
    input wire waitrequest_o,
    input wire nv_store_o,
    input wire [15:0] array_index_pointer_o
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Read finishing in this cycle
    wire rd_done = read_i & ~waitrequest_o;
    a_wait_first: assert property ($rose(read_i) || $rose(write_i) |-> waitrequest_o)
        else $error("no wait on first cycle");
    a_one_wait: assert property (waitrequest_o |=> !waitrequest_o)
        else $error("wait longer than one cycle");
    a_idle_free: assert property (!(read_i || write_i) |-> !waitrequest_o)
        else $error("wait with no access");
    a_rdata_hold: assert property (!$past(read_i) |-> $stable(readdata_o))
        else $error("read data moved without a read");
    // Pointer only moves on a decoded request
    a_index_src: assert property ($changed(array_index_pointer_o) |->
        $past(write_i) && $past(address_i) == `OFS_GO)
        else $error("pointer moved without a request");
    a_nv_src: assert property ($changed(nv_store_o) |-> $past(write_i) &&
        ($past(address_i) == `OFS_GO || $past(address_i) == `OFS_COIL2))
        else $error("store target moved without a write");
    a_index_read: assert property (rd_done && address_i == `OFS_INDEX |->
        readdata_o[15:0] == array_index_pointer_o)
        else $error("pointer readback differs");
    a_nv_read: assert property (rd_done && address_i == `OFS_COIL2 |->
        readdata_o[0] == nv_store_o)
        else $error("storage coil readback differs");
endmodule // decoder_checker

/* plc_master.sv */
// Request source model: drives the decoder's register bus
`timescale 1ns/1ns
module plc_master (
    input wire clock_i,
    input wire waitrequest_i,
    input wire [31:0] readdata_i,
    output reg [5:0] address_o,
    output reg read_o,
    output reg write_o,
    output reg [31:0] writedata_o,
    output reg stall_o
);
    // ****
    // Bus access
    // ****
    // Idle bus from time zero
    initial begin
        address_o = 6'h00;
        read_o = 1'b0;
        write_o = 1'b0;
        writedata_o = 32'h00000000;
        stall_o = 1'b0;
    end
    // One access, held until waitrequest is seen low
    task access(input rd, input [5:0] a, input [31:0] d, output [31:0] q);
        integer n;
        begin
            @(posedge clock_i);
            address_o <= a;
            read_o <= rd;
            write_o <= ~rd;
            writedata_o <= d; // Values only ever travel as integers
            n = 0;
            // Waitrequest is seen at each rising edge, before the slave's update lands
            @(posedge clock_i);
            while (waitrequest_i !== 1'b0 && n < 50) begin
                n = n + 1;
                @(posedge clock_i);
            end
            // A slave that never answers ends the run
            if (n >= 50) begin
                stall_o <= 1'b1;
            end
            // Data is taken and the request dropped at the edge that ended the wait
            q = readdata_i;
            read_o <= 1'b0;
            write_o <= 1'b0;
        end
    endtask
endmodule // plc_master

/* tb_fieldbus_slave_function_decoder.sv */
// Testbench for the fieldbus slave function decoder
`timescale 1ns/1ns
`include "fieldbus_slave_function_decoder_defs.vh"
module tb_fieldbus_slave_function_decoder;
    // ****
    // Harness
    // ****
    reg clock_i = 1'b0;
    reg rst_i = 1'b1;
    wire [5:0] adr;
    wire rd_s, wr_s, wreq, nv;
    wire [31:0] wdat, rdat;
    wire [15:0] ptr;
    wire stall;
    integer fails = 0;
    integer samples_checked = 0;
    integer i;
    reg [31:0] q, res;
    reg [7:0] sa = 8'h01; // Slave address in requests
    reg ok = 1'b1; // Frame check flag in requests
    reg [7:0] f;
    localparam [71:0] FNS = 72'h01_03_05_06_0F_10_0B_11_17;
    localparam [55:0] SUBS = 56'h01_02_0A_0B_0C_0D_0E;
    always #20 clock_i = ~clock_i;
    fieldbus_slave_function_decoder dut (.clock_i(clock_i), .rst_i(rst_i),
        .address_i(adr), .read_i(rd_s), .write_i(wr_s), .writedata_i(wdat),
        .readdata_o(rdat), .waitrequest_o(wreq), .nv_store_o(nv),
        .array_index_pointer_o(ptr));
    plc_master m (.clock_i(clock_i), .waitrequest_i(wreq), .readdata_i(rdat),
        .address_o(adr), .read_o(rd_s), .write_o(wr_s), .writedata_o(wdat),
        .stall_o(stall));
    task check(input [31:0] seen, input [31:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                fails = fails + 1;
                $display("unexpected at %0t: saw %h want %h", $time, seen, want);
            end
        end
    endtask
    task wr(input [5:0] a, input [31:0] d);
        begin
            m.access(1'b0, a, d, q);
        end
    endtask
    task rd(input [5:0] a);
        begin
            m.access(1'b1, a, 32'h00000000, q);
        end
    endtask
    // Load a request, decode it, fetch result and data
    task go(input [7:0] fn, input [31:0] ad, input [31:0] ln);
        begin
            wr(`OFS_REQ_HDR, {15'h0000, ok, fn, sa});
            wr(`OFS_REQ_ADR, ad);
            wr(`OFS_REQ_LEN, ln);
            wr(`OFS_GO, 32'h00000000);
            rd(`OFS_RESULT);
            res = q;
            rd(`OFS_RDATA);
        end
    endtask
    // Response function and exception code
    task ex(input [7:0] fn, input [7:0] e);
        begin
            check({16'h0000, res[15:0]}, {16'h0000, e, fn});
        end
    endtask
    task complete_run;
        begin
            $display("fails=%0d samples_checked=%0d", fails, samples_checked);
            if (fails == 0 && samples_checked > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    // A hung access counts against the run
    always @(posedge stall) begin
        fails = fails + 1;
        complete_run;
    end
    // ****
    // Scenarios
    // ****
    initial begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        check({31'h0, nv}, 32'h00000000);
        rd(6'h3C);
        check(q, 32'h00000000);
        go(`FN_RD_HREGS, 32'h0001_0014, 32'h0);
        ex(8'h83, `EXC_FUNC);
        wr(`OFS_CTRL, 32'h0000_0101);
        for (i = 0; i < 9; i = i + 1) begin
            f = FNS[71 - 8 * i -: 8];
            go(f, (f == `FN_WR_COIL) ? 32'h0 : 32'h0001_0000,
                (f == `FN_WR_COILS) ? 32'h1 : (f == `FN_WR_HREGS) ? 32'h2 : 32'h0);
            ex(f, `EXC_NONE);
        end
        go(8'h02, 32'h0001_0000, 32'h0);
        ex(8'h82, `EXC_FUNC);
        for (i = 0; i < 7; i = i + 1) begin
            go(`FN_DIAG, {24'h0, SUBS[55 - 8 * i -: 8]}, 32'h0);
            ex(`FN_DIAG, `EXC_NONE);
        end
        // Clear counted itself, then four more messages
        rd(`OFS_CNT_SLV);
        check(q, 32'h0005_0000);
        go(`FN_DIAG, 32'h3, 32'h0);
        ex(8'h88, `EXC_FUNC);
        // Last register reachable, one past it refused
        go(`FN_RD_HREGS, {16'd10, 16'd9990}, 32'h0);
        ex(`FN_RD_HREGS, `EXC_NONE);
        go(`FN_RD_HREGS, {16'd10, 16'd9991}, 32'h0);
        ex(8'h83, `EXC_ADDR);
        go(`FN_RD_COILS, {16'd2, 16'd95}, 32'h0);
        ex(8'h81, `EXC_ADDR);
        go(`FN_RD_HREGS, {16'd11, 16'd20}, 32'h0);
        ex(8'h83, `EXC_VALUE);
        go(`FN_RD_HREGS, {16'd0, 16'd20}, 32'h0);
        ex(8'h83, `EXC_VALUE);
        go(`FN_WR_HREG, {16'hFFFF, 16'd20}, 32'h0);
        ex(`FN_WR_HREG, `EXC_NONE);
        go(`FN_WR_COIL, {16'h1234, 16'd0}, 32'h0);
        ex(8'h85, `EXC_VALUE);
        wr(`OFS_CTRL, 32'h0000_0301);
        go(`FN_RD_HREGS, {16'd1, 16'd20}, 32'h0);
        ex(8'h83, `EXC_FAIL);
        wr(`OFS_CTRL, 32'h0000_0101);
        // Register 3120 and register 3411 on the wire as number minus one
        go(`FN_RD_HREGS, {16'd1, 16'd3119}, 32'h0);
        rd(`OFS_PARAM);
        check({12'h0, q[19:0]}, {16'h0, 16'd312});
        go(`FN_RD_HREGS, {16'd2, 16'd3410}, 32'h0);
        rd(`OFS_PARAM);
        check({12'h0, q[19:0]}, {12'h0, 4'h1, 16'd341});
        check({24'h0, res[23:16]}, 32'h4);
        // Pointer set first, then used
        go(`FN_WR_HREG, {16'd2, 16'd8}, 32'h0);
        check({16'h0, ptr}, 32'h2);
        go(`FN_RD_HREGS, {16'd1, 16'd8}, 32'h0);
        check(q, 32'h2);
        rd(`OFS_INDEX);
        check(q, 32'h2);
        // Coil 65 sits at wire address 64
        go(`FN_WR_COIL, {`FORCE_ON, 16'd64}, 32'h0);
        check({31'h0, nv}, 32'h1);
        rd(`OFS_COIL2);
        check({31'h0, q[0]}, 32'h1);
        go(`FN_WR_COIL, {`FORCE_OFF, 16'd64}, 32'h0);
        check({31'h0, nv}, 32'h0);
        wr(`OFS_COIL1, 32'h0000_0607);
        go(`FN_RD_COILS, {16'd16, 16'd32}, 32'h0);
        check(q, 32'h0000_0607);
        go(`FN_RD_COILS, {16'd10, 16'd32}, 32'h0);
        check(q, 32'h0000_0207);
        check({24'h0, res[23:16]}, 32'h2);
        sa = `BCAST_ADDR;
        go(`FN_RD_COILS, {16'd1, 16'd0}, 32'h0);
        check({30'h0, res[25:24]}, 32'h0);
        sa = 8'h07;
        go(`FN_WR_HREG, {16'h5555, 16'd30}, 32'h0);
        check({30'h0, res[25:24]}, 32'h0);
        sa = 8'h01;
        ok = 1'b0;
        go(`FN_WR_HREG, {16'h5555, 16'd30}, 32'h0);
        check({30'h0, res[25:24]}, 32'h0);
        ok = 1'b1;
        // Six stored characters read long and short
        go(`FN_RD_HREGS, {16'd10, 16'd100}, 32'h0001_0600);
        check({24'h0, res[23:16]}, 32'h6);
        go(`FN_RD_HREGS, {16'd2, 16'd100}, 32'h0001_0600);
        check({24'h0, res[23:16]}, 32'h4);
        check(q, 32'h20);
        // Length field keeps what was written; the 20-character cap acts in decode
        wr(`OFS_REQ_LEN, 32'h0001_1500);
        rd(`OFS_REQ_LEN);
        check({24'h0, q[15:8]}, 32'h15);
        go(`FN_RD_HREGS, {16'd10, 16'd100}, 32'h0001_1500);
        check({24'h0, res[23:16]}, 32'h14);
        go(`FN_WR_HREG, {16'd1, 16'd100}, 32'h0001_0000);
        ex(8'h86, `EXC_VALUE);
        go(`FN_WR_HREG, {16'd1, 16'd100}, 32'h0002_0000);
        ex(8'h86, `EXC_VALUE);
        complete_run;
    end
endmodule // tb_fieldbus_slave_function_decoder
bind fieldbus_slave_function_decoder decoder_checker chk (.clock_i(clock_i),
    .rst_i(rst_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .nv_store_o(nv_store_o), .array_index_pointer_o(array_index_pointer_o));
